//--- design/trig_gate_pkg.sv
// Constants and carriers for the analog trigger gate generator.
// Assumes samples arrive already converted to signed millivolts.
package trig_gate_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] TRIGGER_OR_MASK_ADDR         = 16'h9dda;
  localparam logic [15:0] TRIGGER_AND_MASK_ADDR        = 16'h9dee;
  localparam logic [15:0] MAIN_INPUT_TRIGGER_MODE_ADDR = 16'h9e3e;
  localparam logic [15:0] SEC_INPUT_TRIGGER_MODE_ADDR  = 16'h9e3f;
  localparam logic [15:0] MAIN_INPUT_LEVEL_A_ADDR      = 16'ha550;
  localparam logic [15:0] SEC_INPUT_LEVEL_ADDR         = 16'ha551;
  localparam logic [15:0] MAIN_INPUT_LEVEL_B_ADDR      = 16'ha55a;

  // ----------------------------------------
  // Field values
  // ----------------------------------------
  localparam logic [31:0] MAIN_INPUT_MASK_BIT      = 32'h0000_0002;
  localparam logic [31:0] SECONDARY_INPUT_MASK_BIT = 32'h0000_0004;
  localparam logic [31:0] RISING_EDGE_MODE         = 32'h0000_0001;
  localparam logic [31:0] FALLING_EDGE_MODE        = 32'h0000_0002;
  localparam logic [31:0] REARM_FLAG               = 32'h0100_0000;
  localparam logic [31:0] REG_RESET                = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ            = 32'h0000_0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic               valid;
    logic signed [31:0] main_mv;
    logic signed [31:0] sec_mv;
  } sample_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

endpackage

//--- design/analog_trigger_gate_generator.sv
// Gate generator for gated replay driven by two external analog inputs.
// Assumes samples and replay data come from logic on clk_i.
//
// What this block does
// - Input triggers only when enabled in a mask
// - Mask bit 2h main, 4h secondary
// - Separate readable/writable OR and AND masks
// - Re-arm modes only on main input
// - Evaluate crossings on every sample strobe
// - Rising mode: upward crossing opens gate
// - Rising mode: downward crossing closes gate
// - Level present at start never opens gate
// - Falling mode: downward crossing opens gate
// - Falling mode: upward crossing closes gate
// - Re-arm rising: re-arm up arms, trigger opens
// - Opening disarms; wait for next re-arm crossing
// - Re-arm rising: downward crossing closes gate
// - Re-arm falling: re-arm down arms, trigger opens
// - Re-arm falling: upward crossing closes gate
// - Level roles swap between re-arm polarities
// - Each input has its own mode
// - Replay data passes only while gate open
`timescale 1ns/10ps
module analog_trigger_gate_generator #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // Register port
  input  wire trig_gate_pkg::reg_req_s         reg_req_i,
  output logic                    [31:0]       reg_rdata_o,
  // Run control and trigger samples
  input  wire logic                            run_i,
  input  wire trig_gate_pkg::sample_s          sample_i,
  // Replay data and gate output
  input  wire logic                            replay_valid_i,
  input  wire logic               [DATA_W-1:0] replay_data_i,
  output logic                                 out_valid_o,
  output logic                    [DATA_W-1:0] out_data_o,
  output logic                                 gate_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic        [31:0] trigger_or_mask_r;
  logic        [31:0] trigger_and_mask_r;
  logic        [31:0] main_input_trigger_mode_r;
  logic        [31:0] secondary_input_trigger_mode_r;
  logic signed [31:0] main_input_level_a_r;
  logic signed [31:0] main_input_level_b_r;
  logic signed [31:0] secondary_input_level_r;
  logic        [31:0] rdata_nxt;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Writes to unmapped addresses fall through and are dropped
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      trigger_or_mask_r  <= trig_gate_pkg::REG_RESET;
      trigger_and_mask_r <= trig_gate_pkg::REG_RESET;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        trig_gate_pkg::TRIGGER_OR_MASK_ADDR:  trigger_or_mask_r  <= reg_req_i.wdata;
        trig_gate_pkg::TRIGGER_AND_MASK_ADDR: trigger_and_mask_r <= reg_req_i.wdata;
        default:                              ;
      endcase
    end
  end

  // Mode words kept whole; codes outside the four edge modes leave the input off
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      main_input_trigger_mode_r      <= trig_gate_pkg::REG_RESET;
      secondary_input_trigger_mode_r <= trig_gate_pkg::REG_RESET;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        trig_gate_pkg::MAIN_INPUT_TRIGGER_MODE_ADDR: main_input_trigger_mode_r      <= reg_req_i.wdata;
        trig_gate_pkg::SEC_INPUT_TRIGGER_MODE_ADDR:  secondary_input_trigger_mode_r <= reg_req_i.wdata;
        default:                                     ;
      endcase
    end
  end

  // Levels are signed mV; a new level counts from the next sample on
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      main_input_level_a_r    <= trig_gate_pkg::REG_RESET;
      main_input_level_b_r    <= trig_gate_pkg::REG_RESET;
      secondary_input_level_r <= trig_gate_pkg::REG_RESET;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        trig_gate_pkg::MAIN_INPUT_LEVEL_A_ADDR: main_input_level_a_r    <= reg_req_i.wdata;
        trig_gate_pkg::MAIN_INPUT_LEVEL_B_ADDR: main_input_level_b_r    <= reg_req_i.wdata;
        trig_gate_pkg::SEC_INPUT_LEVEL_ADDR:    secondary_input_level_r <= reg_req_i.wdata;
        default:                                ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // A read in the cycle of a write to the same address returns the old value
  always_comb
  begin
    unique case (reg_req_i.addr)
      trig_gate_pkg::TRIGGER_OR_MASK_ADDR:         rdata_nxt = trigger_or_mask_r;
      trig_gate_pkg::TRIGGER_AND_MASK_ADDR:        rdata_nxt = trigger_and_mask_r;
      trig_gate_pkg::MAIN_INPUT_TRIGGER_MODE_ADDR: rdata_nxt = main_input_trigger_mode_r;
      trig_gate_pkg::SEC_INPUT_TRIGGER_MODE_ADDR:  rdata_nxt = secondary_input_trigger_mode_r;
      trig_gate_pkg::MAIN_INPUT_LEVEL_A_ADDR:      rdata_nxt = main_input_level_a_r;
      trig_gate_pkg::MAIN_INPUT_LEVEL_B_ADDR:      rdata_nxt = main_input_level_b_r;
      trig_gate_pkg::SEC_INPUT_LEVEL_ADDR:         rdata_nxt = secondary_input_level_r;
      default:                                     rdata_nxt = trig_gate_pkg::UNMAPPED_READ;
    endcase
  end

  // Read data registered, valid one cycle after the read strobe
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= trig_gate_pkg::UNMAPPED_READ;
    else if (reg_req_i.rd)
      reg_rdata_o <= rdata_nxt;
  end

  // ----------------------------------------
  // Per-input edge engines
  // ----------------------------------------
  logic        [31:0] mode    [2];
  logic signed [31:0] cur     [2];
  logic signed [31:0] trig_lv [2];
  logic signed [31:0] arm_lv  [2];
  logic               engine_gate [2];

  always_comb
  begin
    mode[0] = main_input_trigger_mode_r;
    mode[1] = secondary_input_trigger_mode_r;
    cur[0]  = sample_i.main_mv;
    cur[1]  = sample_i.sec_mv;
    // Level roles follow the re-arm polarity
    // Plain falling mode still triggers on level a, like plain rising
    if (main_input_trigger_mode_r == (trig_gate_pkg::REARM_FLAG | trig_gate_pkg::FALLING_EDGE_MODE))
    begin
      trig_lv[0] = main_input_level_b_r;
      arm_lv[0]  = main_input_level_a_r;
    end
    else
    begin
      trig_lv[0] = main_input_level_a_r;
      arm_lv[0]  = main_input_level_b_r;
    end
    trig_lv[1] = secondary_input_level_r;
    arm_lv[1]  = secondary_input_level_r;
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_engine
    logic signed [31:0] prev_r;
    logic               prev_ok_r;
    logic               gate_r;
    logic               armed_r;
    logic               rearm;
    logic               pos;
    logic               neg;
    logic               up_trig;
    logic               dn_trig;
    logic               up_arm;
    logic               dn_arm;
    logic               step;

    // Secondary input has one level only, so re-arm codes are not honoured there
    assign rearm = (mode[i] == (trig_gate_pkg::REARM_FLAG | trig_gate_pkg::RISING_EDGE_MODE) ||
                    mode[i] == (trig_gate_pkg::REARM_FLAG | trig_gate_pkg::FALLING_EDGE_MODE))
                   && (i == 0);
    assign pos   = (mode[i] == trig_gate_pkg::RISING_EDGE_MODE) ||
                   (rearm && mode[i][1:0] == trig_gate_pkg::RISING_EDGE_MODE[1:0]);
    assign neg   = (mode[i] == trig_gate_pkg::FALLING_EDGE_MODE) ||
                   (rearm && mode[i][1:0] == trig_gate_pkg::FALLING_EDGE_MODE[1:0]);

    // First sample after start only seeds history, so a static level never opens
    assign step    = run_i && sample_i.valid && prev_ok_r;
    assign up_trig = step && (prev_r <  trig_lv[i]) && (cur[i] >= trig_lv[i]);
    assign dn_trig = step && (prev_r >= trig_lv[i]) && (cur[i] <  trig_lv[i]);
    assign up_arm  = step && (prev_r <  arm_lv[i])  && (cur[i] >= arm_lv[i]);
    assign dn_arm  = step && (prev_r >= arm_lv[i])  && (cur[i] <  arm_lv[i]);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        prev_r    <= '0;
        prev_ok_r <= 1'b0;
      end
      else if (!run_i)
        prev_ok_r <= 1'b0;
      else if (sample_i.valid)
      begin
        prev_r    <= cur[i];
        prev_ok_r <= 1'b1;
      end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        gate_r <= 1'b0;
      else if (!run_i)
        gate_r <= 1'b0;
      else if (pos)
      begin
        if (up_trig && (!rearm || armed_r))
          gate_r <= 1'b1;
        else if (dn_trig)
          gate_r <= 1'b0;
      end
      else if (neg)
      begin
        if (dn_trig && (!rearm || armed_r))
          gate_r <= 1'b1;
        else if (up_trig)
          gate_r <= 1'b0;
      end
      else
        gate_r <= 1'b0;
    end

    // Re-arm crossing wins over a same-sample trigger so it is not lost
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        armed_r <= 1'b0;
      else if (!run_i || !rearm)
        armed_r <= 1'b0;
      else if ((pos && up_arm) || (neg && dn_arm))
        armed_r <= 1'b1;
      else if ((pos && up_trig) || (neg && dn_trig))
        armed_r <= 1'b0;
    end

    assign engine_gate[i] = gate_r;
  end

  // ----------------------------------------
  // Mask combination and replay gating
  // ----------------------------------------
  logic [1:0] or_en;
  logic [1:0] and_en;
  logic [1:0] src;
  logic       gate_nxt;

  assign or_en  = {|(trigger_or_mask_r  & trig_gate_pkg::SECONDARY_INPUT_MASK_BIT),
                   |(trigger_or_mask_r  & trig_gate_pkg::MAIN_INPUT_MASK_BIT)};
  assign and_en = {|(trigger_and_mask_r & trig_gate_pkg::SECONDARY_INPUT_MASK_BIT),
                   |(trigger_and_mask_r & trig_gate_pkg::MAIN_INPUT_MASK_BIT)};
  assign src    = {engine_gate[1], engine_gate[0]};
  // Mask writes act at once; stop the run first or an open engine gates straight through
  // Unmasked inputs never act as sources
  assign gate_nxt = |(or_en & src) || ((and_en != 2'b00) && ((and_en & src) == and_en));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gate_o <= 1'b0;
    else
      gate_o <= gate_nxt;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else
    begin
      out_valid_o <= replay_valid_i && gate_o;
      if (replay_valid_i && gate_o)
        out_data_o <= replay_data_i;
    end
  end

endmodule

//--- testbench/trig_gate_asserts.sv
// Checker for the trigger gate generator, watching only its top ports.
// Assumes the design package is compiled first; bound below the module.
`timescale 1ns/10ps
module trig_gate_asserts #(
  parameter int DATA_W = 16
) (
  // Clock, reset, registers
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire trig_gate_pkg::reg_req_s reg_req_i,
  input  wire logic [31:0]             reg_rdata_o,
  // Samples and replay
  input  wire logic                    run_i,
  input  wire trig_gate_pkg::sample_s  sample_i,
  input  wire logic                    replay_valid_i,
  input  wire logic [DATA_W-1:0]       replay_data_i,
  input  wire logic                    out_valid_o,
  input  wire logic [DATA_W-1:0]       out_data_o,
  input  wire logic                    gate_o
);
  logic [31:0] or_shadow_r;
  logic        mapped;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Mirror of the OR mask, so a read is tied to the last write
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      or_shadow_r <= trig_gate_pkg::REG_RESET;
    else if (reg_req_i.wr && reg_req_i.addr == trig_gate_pkg::TRIGGER_OR_MASK_ADDR)
      or_shadow_r <= reg_req_i.wdata;
  end

  assign mapped = reg_req_i.addr inside {trig_gate_pkg::TRIGGER_OR_MASK_ADDR, trig_gate_pkg::TRIGGER_AND_MASK_ADDR,
    trig_gate_pkg::MAIN_INPUT_TRIGGER_MODE_ADDR, trig_gate_pkg::SEC_INPUT_TRIGGER_MODE_ADDR,
    trig_gate_pkg::MAIN_INPUT_LEVEL_A_ADDR, trig_gate_pkg::SEC_INPUT_LEVEL_ADDR, trig_gate_pkg::MAIN_INPUT_LEVEL_B_ADDR};

  AST_PASS_VALID: assert property (out_valid_o == $past(replay_valid_i && gate_o))
    else $error("replay word passed or lost wrongly");
  AST_PASS_DATA: assert property (out_valid_o |-> out_data_o == $past(replay_data_i))
    else $error("replay data not passed");
  AST_HOLD_DATA: assert property (!out_valid_o |-> $stable(out_data_o))
    else $error("paused data changed");
  AST_RUN_LOW_SHUT: assert property (!run_i [*2] |=> !gate_o)
    else $error("gate open while stopped");
  AST_GATE_BY_SAMPLE: assert property ($rose(gate_o) |-> $past(sample_i.valid && run_i, 2))
    else $error("gate opened without a sample");
  AST_UNMAPPED_ZERO: assert property (reg_req_i.rd && !mapped |=> reg_rdata_o == trig_gate_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");
  AST_OR_MASK_READ: assert property (reg_req_i.rd && reg_req_i.addr == trig_gate_pkg::TRIGGER_OR_MASK_ADDR
    |=> reg_rdata_o == $past(or_shadow_r))
    else $error("OR mask read back wrong");
  AST_RDATA_HOLD: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule

bind analog_trigger_gate_generator trig_gate_asserts #(.DATA_W(DATA_W)) chk_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .run_i(run_i),
  .sample_i(sample_i), .replay_valid_i(replay_valid_i), .replay_data_i(replay_data_i),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .gate_o(gate_o));

//--- testbench/trig_source.sv
// Analog trigger source: two millivolt levels sampled at a fixed rate.
// Assumes the bench changes levels off the clock edge.
`timescale 1ns/10ps
module trig_source #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  // Levels in, samples out
  input  wire logic signed [31:0] main_mv_i,
  input  wire logic signed [31:0] sec_mv_i,
  output trig_gate_pkg::sample_s  sample_o
);
  int cnt_r;

  // Between strobes the data lines carry junk, not the last sample
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r    <= 0;
      sample_o <= '0;
    end
    else
    begin
      cnt_r    <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      sample_o <= (cnt_r == PERIOD - 1) ? {1'b1, main_mv_i, sec_mv_i} : {1'b0, ~main_mv_i, ~sec_mv_i};
    end
  end
endmodule

//--- testbench/analog_trigger_gate_generator_test.sv
// Bench for the trigger gate generator: registers, edge and re-arm modes, masks, replay.
// Assumes the package, checker and source model are compiled first.
`timescale 1ns/10ps
module analog_trigger_gate_generator_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [31:0] MB = trig_gate_pkg::MAIN_INPUT_MASK_BIT;
  localparam logic [31:0] SB = trig_gate_pkg::SECONDARY_INPUT_MASK_BIT;
  localparam logic [31:0] RE = trig_gate_pkg::RISING_EDGE_MODE;
  localparam logic [31:0] FE = trig_gate_pkg::FALLING_EDGE_MODE;
  localparam logic [31:0] RA = trig_gate_pkg::REARM_FLAG;
  localparam logic [15:0] ADDRS [7] = '{trig_gate_pkg::TRIGGER_OR_MASK_ADDR, trig_gate_pkg::TRIGGER_AND_MASK_ADDR,
    trig_gate_pkg::MAIN_INPUT_TRIGGER_MODE_ADDR, trig_gate_pkg::SEC_INPUT_TRIGGER_MODE_ADDR,
    trig_gate_pkg::MAIN_INPUT_LEVEL_A_ADDR, trig_gate_pkg::SEC_INPUT_LEVEL_ADDR, trig_gate_pkg::MAIN_INPUT_LEVEL_B_ADDR};
  logic                    clk_i = 1'b0;
  logic                    reset_n_i = 1'b0;
  trig_gate_pkg::reg_req_s req = '0;
  trig_gate_pkg::sample_s  smp;
  logic             [31:0] rdata;
  logic signed      [31:0] main_mv = 0;
  logic signed      [31:0] sec_mv = 0;
  logic                    run = 1'b0;
  logic                    rvalid = 1'b0;
  logic             [15:0] rdat = 16'h0000;
  logic             [15:0] odata;
  logic                    ovalid;
  logic                    gate;
  int                      n_errors = 0;
  int                      compares = 0;
  int                      cyc = 0;

  always #2 clk_i = ~clk_i;

  trig_source src (.clk_i(clk_i), .reset_n_i(reset_n_i), .main_mv_i(main_mv), .sec_mv_i(sec_mv), .sample_o(smp));
  analog_trigger_gate_generator #(.DATA_W(16)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .run_i(run), .sample_i(smp), .replay_valid_i(rvalid), .replay_data_i(rdat),
    .out_valid_o(ovalid), .out_data_o(odata), .gate_o(gate));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i) req = {1'b1, 1'b0, a, d};
    @(negedge clk_i) req = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk_i) req = {1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge clk_i) req = '0;
    chk(rdata, e);
  endtask

  // Levels held long enough for one crossing sample and the gate delay
  task automatic st(input int m, input int s, input logic e);
    @(negedge clk_i);
    main_mv = m;
    sec_mv = s;
    repeat (12) @(negedge clk_i);
    chk(gate, e);
  endtask

  // Stop, program all registers in mV, start with the given input levels
  task automatic cfg(input logic [31:0] orm, andm, mm, sm, la, ls, lb, m0, s0);
    logic [31:0] v [7] = '{orm, andm, mm, sm, la, ls, lb};
    @(negedge clk_i) run = 1'b0;
    foreach (v[i]) wr(ADDRS[i], v[i]);
    main_mv = m0;
    sec_mv = s0;
    @(negedge clk_i) run = 1'b1;
    repeat (12) @(negedge clk_i);
    chk(gate, 1'b0);
  endtask

  task automatic rep(input logic [15:0] d, input logic e);
    @(negedge clk_i);
    rvalid = 1'b1;
    rdat = d;
    @(negedge clk_i);
    rvalid = 1'b0;
    chk(ovalid, e);
    if (e) chk(odata, d);
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    foreach (ADDRS[i]) rd(ADDRS[i], trig_gate_pkg::REG_RESET);
    foreach (ADDRS[i]) wr(ADDRS[i], 32'h0000_1000 + i);
    foreach (ADDRS[i]) rd(ADDRS[i], 32'h0000_1000 + i);
    rd(16'h0000, trig_gate_pkg::UNMAPPED_READ);
    cfg(MB, 0, RE, 0, 100, 0, 100, 200, 0);
    st(0, 0, 1'b0);
    st(200, 0, 1'b1);
    rep(16'hbeef, 1'b1);
    st(50, 0, 1'b0);
    rep(16'h1234, 1'b0);
    cfg(MB, 0, FE, 0, 100, 0, -500, 50, 0);
    st(200, 0, 1'b0);
    st(50, 0, 1'b1);
    st(200, 0, 1'b0);
    cfg(MB, 0, RA | RE, 0, 100, 0, -100, 0, 0);
    st(150, 0, 1'b0);
    st(50, 0, 1'b0);
    st(-200, 0, 1'b0);
    st(-50, 0, 1'b0);
    st(150, 0, 1'b1);
    st(50, 0, 1'b0);
    st(150, 0, 1'b0);
    cfg(MB, 0, RA | FE, 0, 100, 0, -100, 0, 0);
    st(-150, 0, 1'b0);
    st(-50, 0, 1'b0);
    st(200, 0, 1'b0);
    st(50, 0, 1'b0);
    st(-150, 0, 1'b1);
    st(-50, 0, 1'b0);
    cfg(SB, 0, 0, RE, 0, 100, 0, 0, 0);
    st(0, 200, 1'b1);
    cfg(SB, 0, 0, FE, 0, 100, 0, 0, 200);
    st(0, 50, 1'b1);
    cfg(MB, 0, 0, RE, 0, 100, 0, 0, 0);
    st(0, 200, 1'b0);
    cfg(SB, 0, 0, RA | RE, 0, 100, 0, 0, 0);
    st(0, 200, 1'b0);
    cfg(0, MB | SB, RE, RE, 100, 100, 100, 0, 0);
    st(200, 0, 1'b0);
    st(200, 200, 1'b1);
    st(200, 50, 1'b0);
    conclude();
  end
endmodule
